// >>> logic/serial_master_pkg.sv
// shared constants, command codes and state types for the master's
// environment, status and counter registers.
// assumes a single 200 MHz clock and synchronous active-low reset.
package serial_master_pkg;

    ////////////////////////////////////////////////////////////////////////
    // clock and time
    localparam int unsigned CLK_MHZ          = 200;
    localparam int unsigned TICK_US          = 1;
    localparam int unsigned TICK_CYCLES      = TICK_US * CLK_MHZ;
    localparam int unsigned BREAK_PERIOD_MS  = 250;
    localparam int unsigned BREAK_PERIOD_CYC = BREAK_PERIOD_MS * 1000
                                               * CLK_MHZ;

    ////////////////////////////////////////////////////////////////////////
    // command words
    localparam logic [7:0]  CMD_INT_CLR_HI   = 8'h04;
    localparam logic [15:0] CMD_ERR_CLEAR    = 16'h0600;
    localparam logic [15:0] CMD_BREAK        = 16'h0610;
    localparam logic [15:0] CMD_ENV_WRITE    = 16'h5500;
    localparam logic [15:0] CMD_ENV_READ     = 16'h6500;
    localparam logic [15:0] CMD_ERR_READ     = 16'h6501;
    localparam logic [15:0] CMD_CYCLE_READ   = 16'h6502;
    localparam logic [15:0] CMD_RESP_READ    = 16'h6503;
    localparam logic [15:0] CMD_VER_READ     = 16'h6504;

    ////////////////////////////////////////////////////////////////////////
    // environment register layout
    localparam int unsigned ENV_MASK_LSB     = 0;
    localparam int unsigned ENV_BREAK_OFF    = 8;
    localparam int unsigned ENV_CLR_MODE     = 9;
    localparam logic [15:0] ENV_WRITABLE     = 16'h037f;
    localparam logic [15:0] ENV_RESET        = 16'h0000;

    // status flag bits, same order as the mask bits
    localparam int unsigned ST_DONE          = 0;
    localparam int unsigned ST_BREAK         = 1;
    localparam int unsigned ST_PORT_CHG      = 2;
    localparam int unsigned ST_IO_ERR        = 3;
    localparam int unsigned ST_DATA_ERR      = 4;
    localparam int unsigned ST_RXA_ERR       = 5;
    localparam int unsigned ST_ABORT         = 6;
    localparam logic [6:0]  ST_CLEARABLE     = 7'h73;
    localparam logic [6:0]  ST_RESET         = 7'h00;

    // counter values
    localparam logic [15:0] COUNT_MAX        = 16'hffff;
    localparam logic [15:0] COUNT_RESET      = 16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // types
    typedef struct packed {
        logic abort;
        logic rx_addr_err;
        logic data_err;
        logic io_err;
        logic port_chg;
        logic brk;
        logic done;
    } comm_events_t;

    typedef struct packed {
        logic [15:0] env;
        logic [6:0]  flags;
        logic [15:0] err_cnt;
        logic [15:0] responder;
        logic [15:0] iobuf;
        logic [31:0] brk_timer;
        logic        brk_check;
        logic        brk_cmd;
    } master_state_t;

    typedef struct packed {
        logic [7:0]  prescale;
        logic [15:0] running;
        logic [15:0] latched;
        logic        sync_prev;
    } cycle_timer_state_t;

    ////////////////////////////////////////////////////////////////////////
    // saturating increment used by both counters
    function automatic logic [15:0] sat_inc16(input logic [15:0] v);
        if (v == COUNT_MAX) begin
            sat_inc16 = COUNT_MAX;
        end else begin
            sat_inc16 = v + 16'h0001;
        end
    endfunction : sat_inc16

endpackage : serial_master_pkg

// >>> logic/sync_cycle_timer.sv
// microsecond interval timer between changes of the cycle sync signal.
// assumes cycle_sync_signal is already synchronous to clk_sys.
`timescale 1ns/1ps
module sync_cycle_timer
    import serial_master_pkg::*;
#(
    parameter int unsigned US_CYCLES = TICK_CYCLES
) (
    input  wire logic        clk_sys,           // system clock
    input  wire logic        resetn,            // sync reset, active low
    input  wire logic        cycle_sync_signal, // sync level from link
    output logic      [15:0] sync_cycle_time    // last full interval, us
);

    cycle_timer_state_t st_reg;
    cycle_timer_state_t st_next;
    logic               us_tick;
    logic               sync_edge;

    ////////////////////////////////////////////////////////////////////////
    // prescaler tick and sync change detection
    assign us_tick   = (st_reg.prescale == 8'(US_CYCLES - 1));
    assign sync_edge = (cycle_sync_signal != st_reg.sync_prev);

    always_comb begin
        st_next           = st_reg;
        st_next.sync_prev = cycle_sync_signal;
        st_next.prescale  = us_tick ? 8'h00 : st_reg.prescale + 8'h01;
        if (sync_edge) begin
            st_next.latched  = st_reg.running;
            st_next.running  = COUNT_RESET;
            st_next.prescale = 8'h00;
        end else if (us_tick) begin
            st_next.running  = sat_inc16(st_reg.running);
        end
    end

    // state register
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            st_reg <= '{prescale: 8'h00, running: COUNT_RESET,
                        latched: COUNT_RESET, sync_prev: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign sync_cycle_time = st_reg.latched;

endmodule : sync_cycle_timer

// >>> logic/serial_master_status_regs.sv
// environment, status and counter registers of the serial master,
// reached through command words and the shared i/o buffer.
// assumes command and event inputs are synchronous one-cycle pulses.
//
// Contract
// - environment bits 0..6 mask the seven status interrupts.
// - masked sources still set their status flag.
// - break-off clear: check for break request every 250 ms.
// - break-off set: no automatic check, host command only.
// - clear-mode zero: reading status clears the five clearable flags.
// - clear-mode one: only the reset command clears, per command bit.
// - read-only 16-bit counter counts every communication error.
// - error counter saturates at its maximum, never wraps.
// - error counter cleared by clear command and by reset.
// - missing system-communication response counts as an error.
// - cycle counter measures microseconds between sync changes.
// - cycle count stops at its ceiling near 65.5 ms.
// - last responder register holds last good data partner, zero at reset.
// - version register always returns one fixed nonzero value.
// - environment write and read commands move data with the buffer.
// - read commands copy counters and responder into the buffer.
`timescale 1ns/1ps
module serial_master_status_regs
    import serial_master_pkg::*;
#(
    // arbitrary identification value, nonzero
    parameter logic [15:0] VERSION_VALUE = 16'h5a3c,
    parameter int unsigned BREAK_CYCLES  = BREAK_PERIOD_CYC,
    parameter int unsigned US_CYCLES     = TICK_CYCLES,
    parameter int unsigned DEV_NUM_W     = 6
) (
    input  wire logic                 clk_sys,         // system clock
    input  wire logic                 resetn,          // sync, active low
    input  wire logic                 cmd_wr,          // command strobe
    input  wire logic [15:0]          cmd_word,        // command word
    input  wire logic                 iobuf_wr,        // host buffer write
    input  wire logic [15:0]          iobuf_wdata,     // host buffer data
    output logic      [15:0]          iobuf_rdata,     // buffer contents
    input  wire logic                 status_rd,       // host status read
    output logic      [15:0]          status_word,     // status flags
    input  wire comm_events_t         comm_events,     // status sources
    input  wire logic                 comm_error_evt,  // any comm error
    input  wire logic                 sys_no_resp_evt, // no response
    input  wire logic                 data_ok_evt,     // data comm done ok
    input  wire logic [DEV_NUM_W-1:0] data_ok_dev,     // its device number
    input  wire logic                 cycle_sync_signal, // sync level
    output logic                      irq_req,         // unmasked status
    output logic                      break_check_req, // periodic check
    output logic                      break_cmd_req    // host break cmd
);

    ////////////////////////////////////////////////////////////////////////
    // declarations

    master_state_t st_reg;
    master_state_t st_next;
    logic [15:0]   cycle_time;
    logic [6:0]    flag_set;
    logic [6:0]    flag_clr;
    logic          clr_mode;
    logic          brk_off;
    logic          is_int_clr;
    logic          err_inc;
    logic          err_clr;
    logic [15:0]   read_value;
    logic          read_hit;

    localparam logic [31:0] BREAK_RELOAD = 32'(BREAK_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////////
    // cycle time measurement

    sync_cycle_timer #(
        .US_CYCLES         (US_CYCLES)
    ) u_cycle_timer (
        .clk_sys           (clk_sys),
        .resetn            (resetn),
        .cycle_sync_signal (cycle_sync_signal),
        .sync_cycle_time   (cycle_time)
    );

    ////////////////////////////////////////////////////////////////////////
    // environment fields

    // break-off and clear-mode controls taken from the environment word
    assign brk_off  = st_reg.env[ENV_BREAK_OFF];
    assign clr_mode = st_reg.env[ENV_CLR_MODE];

    ////////////////////////////////////////////////////////////////////////
    // status flag set and clear terms

    assign flag_set = comm_events;

    // interrupt-status reset command is recognised by its high byte
    assign is_int_clr = cmd_wr && (cmd_word[15:8] == CMD_INT_CLR_HI);

    always_comb begin
        flag_clr = 7'h00;
        if (!clr_mode && status_rd) begin
            flag_clr = ST_CLEARABLE;
        end else if (clr_mode && is_int_clr) begin
            flag_clr = cmd_word[6:0] & ST_CLEARABLE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // error counter terms

    assign err_inc = comm_error_evt || sys_no_resp_evt;

    assign err_clr = cmd_wr && (cmd_word == CMD_ERR_CLEAR);

    ////////////////////////////////////////////////////////////////////////
    // read command mux into the i/o buffer

    always_comb begin
        read_hit   = cmd_wr;
        read_value = 16'h0000;
        unique case (cmd_word)
            CMD_ENV_READ:   read_value = st_reg.env;
            CMD_ERR_READ:   read_value = st_reg.err_cnt;
            CMD_CYCLE_READ: read_value = cycle_time;
            CMD_RESP_READ:  read_value = st_reg.responder;
            CMD_VER_READ:   read_value = VERSION_VALUE;
            default:        read_hit   = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        st_next           = st_reg;
        st_next.brk_check = 1'b0;
        st_next.brk_cmd   = 1'b0;

        // an event in the clearing cycle survives the clear
        st_next.flags = (st_reg.flags & ~flag_clr) | flag_set;

        if (err_inc) begin
            st_next.err_cnt = err_clr ? 16'h0001
                                      : sat_inc16(st_reg.err_cnt);
        end else if (err_clr) begin
            st_next.err_cnt = COUNT_RESET;
        end

        if (data_ok_evt) begin
            st_next.responder = 16'(data_ok_dev);
        end

        // host buffer write, then command results override it
        if (iobuf_wr) begin
            st_next.iobuf = iobuf_wdata;
        end
        if (read_hit) begin
            st_next.iobuf = read_value;
        end

        if (cmd_wr && (cmd_word == CMD_ENV_WRITE)) begin
            st_next.env = st_reg.iobuf & ENV_WRITABLE;
        end

        if (cmd_wr && (cmd_word == CMD_BREAK)) begin
            st_next.brk_cmd = 1'b1;
        end

        if (brk_off) begin
            st_next.brk_timer = BREAK_RELOAD;
        end else if (st_reg.brk_timer == 32'h0000_0000) begin
            st_next.brk_timer = BREAK_RELOAD;
            st_next.brk_check = 1'b1;
        end else begin
            st_next.brk_timer = st_reg.brk_timer - 32'h0000_0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            st_reg <= '{env:       ENV_RESET,
                        flags:     ST_RESET,
                        err_cnt:   COUNT_RESET,
                        responder: COUNT_RESET,
                        iobuf:     COUNT_RESET,
                        brk_timer: BREAK_RELOAD,
                        brk_check: 1'b0,
                        brk_cmd:   1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    // status word and buffer straight from flops
    assign status_word     = {9'h000, st_reg.flags};
    assign iobuf_rdata     = st_reg.iobuf;

    assign irq_req = |(st_reg.flags & ~st_reg.env[ENV_MASK_LSB +: 7]);

    // break request pulses
    assign break_check_req = st_reg.brk_check;
    assign break_cmd_req   = st_reg.brk_cmd;

endmodule : serial_master_status_regs

// >>> verif/status_regs_properties.sv
// port-level checks for the status register bank.
// assumes it is bound onto serial_master_status_regs.
`timescale 1ns/1ps
module status_regs_properties
    import serial_master_pkg::*;
#(
    parameter logic [15:0] VERSION_VALUE = 16'h5a3c
) (
    input wire logic         clk_sys,         // clock
    input wire logic         resetn,          // reset, active low
    input wire logic         cmd_wr,          // command strobe
    input wire logic [15:0]  cmd_word,        // command word
    input wire logic         iobuf_wr,        // buffer write
    input wire logic [15:0]  iobuf_wdata,     // buffer data in
    input wire logic [15:0]  iobuf_rdata,     // buffer data out
    input wire logic [15:0]  status_word,     // status flags
    input wire comm_events_t comm_events,     // flag sources
    input wire logic         irq_req,         // interrupt request
    input wire logic         break_check_req, // periodic check
    input wire logic         break_cmd_req    // host break
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    a_version_fixed: assert property (
        cmd_wr && cmd_word == CMD_VER_READ |=> iobuf_rdata == VERSION_VALUE)
        else $error("version read wrong");
    a_env_reserved: assert property (
        cmd_wr && cmd_word == CMD_ENV_READ
        |=> (iobuf_rdata & ~ENV_WRITABLE) == 16'h0000)
        else $error("reserved env bits set");
    a_buf_write: assert property (
        iobuf_wr && !cmd_wr |=> iobuf_rdata == $past(iobuf_wdata))
        else $error("buffer write lost");
    a_flags_set: assert property (
        comm_events != 7'h00
        |=> (status_word[6:0] & $past(comm_events)) == $past(comm_events))
        else $error("event did not set flag");
    a_sticky_flags: assert property (
        status_word[3:2] != 2'b00
        |=> (status_word[3:2] | ~$past(status_word[3:2])) == 2'b11)
        else $error("port or io flag cleared");
    a_irq_idle: assert property (
        status_word[6:0] == 7'h00 |-> !irq_req)
        else $error("irq without flag");
    a_break_cmd: assert property (
        cmd_wr && cmd_word == CMD_BREAK |=> break_cmd_req)
        else $error("break command missing");
    a_break_quiet: assert property (
        !(cmd_wr && cmd_word == CMD_BREAK) |=> !break_cmd_req)
        else $error("spurious break command");
    a_check_pulse: assert property (
        break_check_req |=> !break_check_req)
        else $error("break check not a pulse");
endmodule : status_regs_properties

bind serial_master_status_regs status_regs_properties #(
    .VERSION_VALUE(VERSION_VALUE)) i_props (
    .clk_sys(clk_sys), .resetn(resetn), .cmd_wr(cmd_wr),
    .cmd_word(cmd_word), .iobuf_wr(iobuf_wr), .iobuf_wdata(iobuf_wdata),
    .iobuf_rdata(iobuf_rdata), .status_word(status_word),
    .comm_events(comm_events), .irq_req(irq_req),
    .break_check_req(break_check_req), .break_cmd_req(break_cmd_req));

// >>> verif/host_cpu_model.sv
// host cpu model: command words, buffer moves and status reads.
// assumes the bank samples on the rising edge; drives at falling edge.
`timescale 1ns/1ps
module host_cpu_model
    import serial_master_pkg::*;
(
    input  wire logic        clk_sys,     // system clock
    input  wire logic [15:0] iobuf_rdata, // buffer contents
    output logic             cmd_wr,      // command strobe
    output logic      [15:0] cmd_word,    // command word
    output logic             iobuf_wr,    // buffer write
    output logic      [15:0] iobuf_wdata, // buffer data
    output logic             status_rd    // status read pulse
);
    // idle lines at time zero
    initial begin
        cmd_wr      = 1'b0;
        cmd_word    = 16'h0000;
        iobuf_wr    = 1'b0;
        iobuf_wdata = 16'h0000;
        status_rd   = 1'b0;
    end
    // one command for one cycle; released word shows its inverse
    task automatic cmd(input logic [15:0] w);
        @(negedge clk_sys);
        cmd_wr   = 1'b1;
        cmd_word = w;
        @(negedge clk_sys);
        cmd_wr   = 1'b0;
        cmd_word = ~w;
    endtask : cmd
    // one buffer write
    task automatic wbuf(input logic [15:0] v);
        @(negedge clk_sys);
        iobuf_wr    = 1'b1;
        iobuf_wdata = v;
        @(negedge clk_sys);
        iobuf_wr    = 1'b0;
        iobuf_wdata = ~v;
    endtask : wbuf
    // read command, then take the buffer
    task automatic fetch(input logic [15:0] w, output logic [15:0] v);
        cmd(w);
        v = iobuf_rdata;
    endtask : fetch
    // one status read pulse
    task automatic rd_status;
        @(negedge clk_sys);
        status_rd = 1'b1;
        @(negedge clk_sys);
        status_rd = 1'b0;
    endtask : rd_status
    task automatic ver_check(output logic [15:0] v);
        wbuf(16'h0000);
        fetch(CMD_VER_READ, v);
    endtask : ver_check
endmodule : host_cpu_model

// >>> verif/serial_master_status_regs_test.sv
// self-checking bench for the status register bank.
// assumes the host model owns the command and buffer lines.
`timescale 1ns/1ps
module serial_master_status_regs_test;
    import serial_master_pkg::*;
    localparam logic [15:0] VER = 16'h5a3c; // arbitrary value
    localparam int unsigned BRK = 20;
    localparam int unsigned US  = 4;
    logic         clk_sys = 1'b0;
    logic         resetn, comm_error_evt, sys_no_resp_evt, data_ok_evt;
    logic         cycle_sync_signal, cmd_wr, iobuf_wr, status_rd, irq_req;
    logic         break_check_req, break_cmd_req;
    logic [5:0]   data_ok_dev;
    logic [15:0]  cmd_word, iobuf_wdata, iobuf_rdata, status_word, d, rnd;
    comm_events_t comm_events;
    int           mismatches, check_count, c, k;

    host_cpu_model i_host (.clk_sys(clk_sys), .iobuf_rdata(iobuf_rdata),
        .cmd_wr(cmd_wr), .cmd_word(cmd_word), .iobuf_wr(iobuf_wr),
        .iobuf_wdata(iobuf_wdata), .status_rd(status_rd));
    serial_master_status_regs #(.VERSION_VALUE(VER), .BREAK_CYCLES(BRK),
        .US_CYCLES(US), .DEV_NUM_W(6)) i_dut (
        .clk_sys(clk_sys), .resetn(resetn), .cmd_wr(cmd_wr),
        .cmd_word(cmd_word), .iobuf_wr(iobuf_wr), .iobuf_wdata(iobuf_wdata),
        .iobuf_rdata(iobuf_rdata), .status_rd(status_rd),
        .status_word(status_word), .comm_events(comm_events),
        .comm_error_evt(comm_error_evt), .sys_no_resp_evt(sys_no_resp_evt),
        .data_ok_evt(data_ok_evt), .data_ok_dev(data_ok_dev),
        .cycle_sync_signal(cycle_sync_signal), .irq_req(irq_req),
        .break_check_req(break_check_req), .break_cmd_req(break_cmd_req));

    // 200 MHz clock
    always #2.5 clk_sys = ~clk_sys;

    function automatic logic [15:0] lfsr(input logic [15:0] v);
        lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic finish_test;
        $display("checks=%0d mismatches=%0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test
    task automatic ev(input comm_events_t e);
        @(negedge clk_sys);
        comm_events = e;
        @(negedge clk_sys);
        comm_events = 7'h00;
    endtask : ev
    task automatic set_env(input logic [15:0] v);
        i_host.wbuf(v);
        i_host.cmd(CMD_ENV_WRITE);
    endtask : set_env
    // count periodic break checks over 200 cycles
    task automatic count_brk;
        c = 0;
        repeat (200) begin
            @(posedge clk_sys);
            #1;
            if (break_check_req === 1'b1) c++;
        end
    endtask : count_brk

    // watchdog cuts a hang short
    initial begin
        #450_000;
        mismatches++;
        finish_test();
    end

    // main sequence
    initial begin
        {resetn, comm_error_evt, sys_no_resp_evt, data_ok_evt} = 4'h0;
        {cycle_sync_signal, data_ok_dev, comm_events} = 14'h0000;
        mismatches = 0;
        check_count = 0;
        rnd = 16'h0001;
        repeat (6) @(negedge clk_sys);
        resetn = 1'b1;
        check(status_word, 16'h0000);
        i_host.fetch(CMD_ERR_READ, d);
        check(d, 16'h0000);
        i_host.fetch(CMD_RESP_READ, d);
        check(d, 16'h0000);
        i_host.ver_check(d);
        check(d, VER);
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            set_env(rnd);
            i_host.fetch(CMD_ENV_READ, d);
            check(d, rnd & ENV_WRITABLE);
        end
        set_env(16'h007f);
        ev(7'h7f);
        check(status_word, 16'h007f);
        check({15'h0, irq_req}, 16'h0000);
        for (int i = 0; i < 7; i++) begin
            set_env(16'h007f & ~(16'h0001 << i));
            check({15'h0, irq_req}, 16'h0001);
        end
        i_host.rd_status();
        check(status_word, 16'h000c);
        set_env(16'h0200);
        ev(7'h7f);
        i_host.rd_status();
        check(status_word, 16'h007f);
        i_host.cmd({CMD_INT_CLR_HI, 8'h01});
        check(status_word, 16'h007e);
        i_host.cmd({CMD_INT_CLR_HI, 8'h72});
        check(status_word, 16'h000c);
        set_env(16'h0000);
        ev(7'h01);
        i_host.cmd({CMD_INT_CLR_HI, 8'h01});
        check(status_word, 16'h000d);
        rnd = lfsr(rnd);
        k = rnd[3:0] + 1;
        @(negedge clk_sys);
        comm_error_evt = 1'b1;
        repeat (k) @(negedge clk_sys);
        comm_error_evt = 1'b0;
        sys_no_resp_evt = 1'b1;
        @(negedge clk_sys);
        sys_no_resp_evt = 1'b0;
        i_host.fetch(CMD_ERR_READ, d);
        check(d, 16'(k + 1));
        i_host.cmd(CMD_ERR_CLEAR);
        i_host.fetch(CMD_ERR_READ, d);
        check(d, 16'h0000);
        @(negedge clk_sys);
        comm_error_evt = 1'b1;
        repeat (65540) @(negedge clk_sys);
        comm_error_evt = 1'b0;
        i_host.fetch(CMD_ERR_READ, d);
        check(d, 16'hffff);
        rnd = lfsr(rnd);
        @(negedge clk_sys);
        data_ok_evt = 1'b1;
        data_ok_dev = rnd[5:0];
        @(negedge clk_sys);
        data_ok_evt = 1'b0;
        i_host.fetch(CMD_RESP_READ, d);
        check(d, {10'h000, rnd[5:0]});
        k = 10 + rnd[3:0];
        @(negedge clk_sys);
        cycle_sync_signal = ~cycle_sync_signal;
        repeat (US * k) @(negedge clk_sys);
        cycle_sync_signal = ~cycle_sync_signal;
        i_host.fetch(CMD_CYCLE_READ, d);
        check(16'(d >= k - 1 && d <= k + 1), 16'h0001);
        set_env(16'h0000);
        count_brk();
        check(16'(c >= 9 && c <= 10), 16'h0001);
        set_env(16'h0100);
        count_brk();
        check(16'(c), 16'h0000);
        i_host.cmd(CMD_BREAK);
        check({15'h0, break_cmd_req}, 16'h0001);
        @(negedge clk_sys);
        check({15'h0, break_cmd_req}, 16'h0000);
        finish_test();
    end
endmodule : serial_master_status_regs_test
